/* src/serial_clk_pkg.sv */
// Constants and carrier types for the two-wire port clock/status block.
// Assumes a single 25 MHz core clock.
`default_nettype none
package serial_clk_pkg;
  // ==========================================================
  // Clocking
  localparam int unsigned CLK_HZ = 25_000_000;
  // Divider count rate: oscillator/2 (8 MHz oscillator)
  localparam int unsigned OSC_HZ = 8_000_000;
  localparam int unsigned DIV_TICK_HZ = OSC_HZ / 2;
  // Core cycles per divider tick, rounded down, at least one
  localparam int unsigned TICK_CYC_I =
    (CLK_HZ / DIV_TICK_HZ) < 1 ? 1 : (CLK_HZ / DIV_TICK_HZ);
  localparam logic [3:0] TICK_CYC = 4'(TICK_CYC_I);
  // Least legal reload value; smaller ones are raised to it
  localparam logic [7:0] RELOAD_MIN = 8'h03;
  localparam logic [7:0] RELOAD_RST = 8'h13;

  // ==========================================================
  // Register byte addresses (word aligned)
  localparam logic [4:0] ADDR_RELOAD = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_CTRL = 5'h08;
  localparam logic [4:0] ADDR_IRQ_STAT = 5'h0C;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h10;

  // Status register bit positions
  localparam int unsigned ST_SLEW = 7;
  localparam int unsigned ST_EDGE = 6;
  localparam int unsigned ST_DATA = 5;
  localparam int unsigned ST_STOP = 4;
  localparam int unsigned ST_START = 3;
  // Control register bit positions
  localparam int unsigned CT_EN = 0;
  localparam int unsigned CT_RUN = 1;
  // Interrupt bit positions
  localparam int unsigned IR_START = 0;
  localparam int unsigned IR_STOP = 1;
  localparam int unsigned IR_BYTE = 2;
  localparam int unsigned IRQ_W = 3;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
  } av_req_t;
endpackage
`default_nettype wire

/* src/baud_divider.sv */
// Reloading down-counter that toggles the serial clock on rollover.
// Assumes tick is a one-cycle enable and rst_sync_b is synchronous-released.
`default_nettype none
module baud_divider
  import serial_clk_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_sync_b,
  // Control
  input wire logic tick,
  input wire logic run,
  input wire logic [7:0] reload,
  // Generated clock
  output logic scl_level,
  output logic rollover
);
  typedef struct packed {
    logic [7:0] cnt;
    logic scl;
    logic roll;
  } div_state_t;

  div_state_t s_q, s_d;
  logic [7:0] eff_reload;

  // ==========================================================
  // RULE_06 - invalid reloads raised
  assign eff_reload = (reload < RELOAD_MIN) ? RELOAD_MIN : reload;

  // RULE_01 - two rollovers per period
  always_comb begin
    s_d = s_q;
    s_d.roll = 1'b0;
    if (!run) begin
      s_d.cnt = eff_reload;
      s_d.scl = 1'b1;
    end else if (tick) begin
      if (s_q.cnt == 8'h00) begin
        s_d.cnt = eff_reload;
        s_d.scl = ~s_q.scl;
        s_d.roll = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_q <= '{cnt: RELOAD_RST, scl: 1'b1, roll: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign scl_level = s_q.scl;
  assign rollover = s_q.roll;

  // ==========================================================
  property p_roll_toggle;
    @(posedge clk) disable iff (!rst_sync_b)
    (run && tick && s_q.cnt == 8'h00) |=> (rollover && scl_level != $past(scl_level));
  endproperty
  a_roll_toggle: assert property (p_roll_toggle) // RULE_01
    else $error("rollover did not toggle serial clock");

  property p_cnt_legal;
    @(posedge clk) disable iff (!rst_sync_b)
    run |=> (s_q.cnt <= eff_reload || $past(s_q.cnt) > eff_reload);
  endproperty
  a_cnt_legal: assert property (p_cnt_legal) // RULE_06
    else $error("divider count outside reload range");
endmodule
`default_nettype wire

/* src/serial_clk_status.sv */
// Two-wire port master clock divider with start/stop/byte-type status.
// Assumes Avalon-MM master on clk; pins arrive asynchronously; byte
// events come from port logic on clk.
//
// How it works
// RULE_01 - Reloads 04h, 0Bh, 13h give 400, 166, 100 kHz; two rollovers each. The 6-cycle tick at 25 MHz gives 416.7, 173.6, 104.2 kHz.
// RULE_02 - The 400 kHz rate is not fully fast-mode compliant; use with care.
// RULE_03 - Stop flag reads 1 when stop was the latest condition; 0 at reset.
// RULE_04 - Start flag reads 1 when start was the latest condition; 0 at reset.
// RULE_05 - Clearing port enable clears both start and stop flags.
// RULE_06 - Clock is oscillator over four times reload plus one; 0-2 invalid. Here it is the 25 MHz core clock over 12 times reload plus one.
// RULE_07 - Data flag reads 1 for a data byte, 0 for an address byte.
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`default_nettype none
module serial_clk_status
  import serial_clk_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  // Byte events from the port's shift logic
  input wire logic byte_done,
  input wire logic byte_is_data,
  // Interrupt
  output logic irq
);
  typedef struct packed {
    bus_pins_t sync1;
    bus_pins_t sync2;
    logic sda_prev;
    logic [3:0] tick_cnt;
    logic tick;
    logic ack;
    logic [31:0] rdata;
    logic [7:0] reload;
    logic slew;
    logic edge_sel;
    logic data_flag;
    logic stop_flag;
    logic start_flag;
    logic en;
    logic run;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
  } state_t;

  state_t s_q, s_d;
  logic [1:0] rst_pipe_q;
  logic rst_sync_b;
  logic start_evt, stop_evt, acc, wr_en;
  logic [IRQ_W-1:0] irq_set, irq_clr;
  logic scl_gen;
  av_req_t req;

  // ==========================================================
  // Reset release synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe_q <= 2'b00;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_pipe_q[1];

  // Register read mux
  function automatic logic [31:0] reg_read(input state_t s,
                                           input logic [4:0] a);
    logic [31:0] v;
    v = '0;
    unique case (a)
      ADDR_RELOAD: v[7:0] = s.reload;
      ADDR_STATUS: begin
        v[ST_SLEW] = s.slew;
        v[ST_EDGE] = s.edge_sel;
        v[ST_DATA] = s.data_flag;
        v[ST_STOP] = s.stop_flag;
        v[ST_START] = s.start_flag;
      end
      ADDR_CTRL: begin
        v[CT_EN] = s.en;
        v[CT_RUN] = s.run;
      end
      ADDR_IRQ_STAT: v[IRQ_W-1:0] = s.irq_stat;
      ADDR_IRQ_MASK: v[IRQ_W-1:0] = s.irq_mask;
      default: v = '0;
    endcase
    return v;
  endfunction

  // ==========================================================
  // Bus conditions from synchronised pins
  assign req = '{read: read, write: write, address: address,
                 writedata: writedata};
  assign start_evt = s_q.sync2.scl & s_q.sda_prev & ~s_q.sync2.sda;
  assign stop_evt = s_q.sync2.scl & ~s_q.sda_prev & s_q.sync2.sda;
  assign acc = (req.read | req.write) & s_q.ack;
  assign wr_en = acc & req.write & byteenable[0];
  assign irq_clr = (wr_en && req.address == ADDR_IRQ_STAT) ?
                   req.writedata[IRQ_W-1:0] : '0;
  always_comb begin
    irq_set = '0;
    irq_set[IR_START] = s_q.en & start_evt;
    irq_set[IR_STOP] = s_q.en & stop_evt;
    irq_set[IR_BYTE] = s_q.en & byte_done;
  end

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.sync1 = '{scl: scl_in, sda: sda_in};
    s_d.sync2 = s_q.sync1;
    s_d.sda_prev = s_q.sync2.sda;
    // Divider tick at oscillator/2
    s_d.tick = 1'b0;
    if (s_q.tick_cnt == TICK_CYC - 4'h1) begin
      s_d.tick_cnt = 4'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 4'h1;
    end
    // One wait state, then answer
    s_d.ack = (req.read | req.write) & ~s_q.ack;
    if ((req.read | req.write) & ~s_q.ack) begin
      s_d.rdata = reg_read(s_q, req.address);
    end
    if (wr_en) begin
      unique case (req.address)
        ADDR_RELOAD: s_d.reload = req.writedata[7:0];
        ADDR_STATUS: begin
          s_d.slew = req.writedata[ST_SLEW];
          s_d.edge_sel = req.writedata[ST_EDGE];
        end
        ADDR_CTRL: begin
          s_d.en = req.writedata[CT_EN];
          s_d.run = req.writedata[CT_RUN];
        end
        ADDR_IRQ_MASK: s_d.irq_mask = req.writedata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // RULE_04 - start seen last
    if (start_evt) begin
      s_d.start_flag = 1'b1;
      s_d.stop_flag = 1'b0;
    end
    // RULE_03 - stop seen last
    if (stop_evt) begin
      s_d.stop_flag = 1'b1;
      s_d.start_flag = 1'b0;
    end
    // RULE_07 - byte type latch
    if (byte_done) begin
      s_d.data_flag = byte_is_data;
    end
    // RULE_05 - disable clears flags
    if (!s_q.en) begin
      s_d.start_flag = 1'b0;
      s_d.stop_flag = 1'b0;
    end
    // Run needs enable; judged on the value being written
    if (!s_d.en) begin
      s_d.run = 1'b0;
    end
    // Sticky events, set wins over clear
    s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;
  end

  // State register
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_q <= '0;
      s_q.sync1 <= '{scl: 1'b1, sda: 1'b1};
      s_q.sync2 <= '{scl: 1'b1, sda: 1'b1};
      s_q.sda_prev <= 1'b1;
      s_q.reload <= RELOAD_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // RULE_06 - master clock divider
  baud_divider u_div (
    .clk(clk),
    .rst_sync_b(rst_sync_b),
    .tick(s_q.tick),
    .run(s_q.en & s_q.run),
    .reload(s_q.reload),
    .scl_level(scl_gen),
    .rollover()
  );

  // Open-drain clock: drive only while low
  assign scl_out = 1'b0;
  assign scl_oe = ~scl_gen;
  assign waitrequest = (req.read | req.write) & ~s_q.ack;
  assign readdata = s_q.rdata;
  assign irq = |(s_q.irq_stat & s_q.irq_mask);

  // ==========================================================
  property p_stop_last;
    @(posedge clk) disable iff (!rst_sync_b)
    (stop_evt && s_q.en) |=> (s_q.stop_flag && !s_q.start_flag);
  endproperty
  a_stop_last: assert property (p_stop_last) // RULE_03
    else $error("stop flag not set after stop");

  property p_start_last;
    @(posedge clk) disable iff (!rst_sync_b)
    (start_evt && s_q.en) |=> (s_q.start_flag && !s_q.stop_flag);
  endproperty
  a_start_last: assert property (p_start_last) // RULE_04
    else $error("start flag not set after start");

  property p_flags_reset;
    @(posedge clk) $rose(rst_sync_b) |-> !s_q.start_flag && !s_q.stop_flag;
  endproperty
  a_flags_reset: assert property (p_flags_reset) // RULE_03
    else $error("flags not zero after reset");

  property p_disable_clear;
    @(posedge clk) disable iff (!rst_sync_b)
    !s_q.en |=> !s_q.start_flag && !s_q.stop_flag;
  endproperty
  a_disable_clear: assert property (p_disable_clear) // RULE_05
    else $error("flags survive port disable");

  property p_byte_type;
    @(posedge clk) disable iff (!rst_sync_b)
    byte_done |=> s_q.data_flag == $past(byte_is_data);
  endproperty
  a_byte_type: assert property (p_byte_type) // RULE_07
    else $error("data flag wrong after byte");

  property p_idle_released;
    @(posedge clk) disable iff (!rst_sync_b)
    !s_q.en ##1 !s_q.en |=> !scl_oe;
  endproperty
  a_idle_released: assert property (p_idle_released) // RULE_01
    else $error("clock driven while port disabled");
endmodule
`default_nettype wire

/* sim/bus_peer.sv */
// Far-side peer on the two-wire bus: makes start and stop conditions.
// Assumes a pulled-up clock line that only the block may pull low.
`default_nettype none
module bus_peer
  import serial_clk_pkg::*;
(
  // Clock
  input wire logic clk,
  // Block's clock pull-down
  input wire logic scl_oe,
  // Resolved wire levels
  output bus_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_q = 1'b1;

  // ==========================================================
  // Wire resolution
  // Pull-up wins unless the block pulls low; peer never stretches
  assign pins.scl = ~scl_oe;
  assign pins.sda = sda_q;

  // ==========================================================
  // Bus conditions
  // peer fast rate
  // Peer conditions step every 8 cycles and ignore the clock line, so the divider must be stopped
  task automatic send_start();
    @(posedge clk);
    sda_q <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // Stop: data rises while clock stays high
  task automatic send_stop();
    @(posedge clk);
    sda_q <= 1'b0;
    repeat (8) @(posedge clk);
    sda_q <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
// Register-level bench for the port clock divider and status flags.
// Assumes the peer model resolves the bus wires.
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
  n_fail++; $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module tb
  import serial_clk_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] ben = 4'hF;
  logic [31:0] rdat;
  logic wreq;
  logic scl_out;
  logic scl_oe;
  logic bdone = 1'b0;
  logic bdata = 1'b0;
  logic irq;
  bus_pins_t pins;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] v;
  int n_lo;
  int n_hi;
  logic [7:0] rl [4] = '{8'h04, 8'h0B, 8'h13, 8'h00};
  int per [4] = '{60, 144, 240, 48};

  always #20 clk = ~clk;

  serial_clk_status i_dut (.clk(clk), .rst_b(rst_b), .address(adr),
    .read(rd), .write(wr), .writedata(wdat), .byteenable(ben),
    .readdata(rdat), .waitrequest(wreq), .scl_in(pins.scl),
    .sda_in(pins.sda), .scl_out(scl_out), .scl_oe(scl_oe),
    .byte_done(bdone), .byte_is_data(bdata), .irq(irq));

  bus_peer i_peer (.clk(clk), .scl_oe(scl_oe), .pins(pins));

  // ==========================================================
  // Bus access tasks
  // Request held until waitrequest is sampled low
  task automatic av(input logic w, input logic [4:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    av(1'b0, a, 32'h0, q);
    `CHK("readdata", e, q)
  endtask

  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(1'b1, a, d, q);
  endtask

  // Cycles until scl_oe reads the given level
  task automatic wait_oe(input logic lv, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (scl_oe !== lv && n < 2000);
  endtask

  // One-cycle byte event
  task automatic byte_ev(input logic is_data);
    @(posedge clk);
    bdone <= 1'b1;
    bdata <= is_data;
    @(posedge clk);
    bdone <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic results();
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(ADDR_RELOAD, 32'h13);
    rchk(ADDR_STATUS, 32'h00); // reset flags clear
    rchk(5'h14, 32'h0);
    `CHK("irq", 1'b0, irq)
    `CHK("scl_out", 1'b0, scl_out)
    ben <= 4'h0;
    wreg(ADDR_RELOAD, 32'h55);
    ben <= 4'hF;
    rchk(ADDR_RELOAD, 32'h13);
    // Start then stop, with interrupt handling
    wreg(ADDR_CTRL, 32'h1);
    i_peer.send_start();
    rchk(ADDR_STATUS, 32'h08); // start latest
    `CHK("irq", 1'b0, irq)
    wreg(ADDR_IRQ_MASK, 32'h7);
    @(posedge clk);
    `CHK("irq", 1'b1, irq)
    i_peer.send_stop();
    rchk(ADDR_STATUS, 32'h10); // stop latest
    byte_ev(1'b1);
    rchk(ADDR_STATUS, 32'h30); // data byte
    rchk(ADDR_IRQ_STAT, 32'h7);
    wreg(ADDR_IRQ_STAT, 32'h7);
    rchk(ADDR_IRQ_STAT, 32'h0);
    `CHK("irq", 1'b0, irq)
    byte_ev(1'b0);
    rchk(ADDR_STATUS, 32'h10); // address byte
    wreg(ADDR_STATUS, 32'hFF);
    rchk(ADDR_STATUS, 32'hD0);
    wreg(ADDR_STATUS, 32'h00);
    i_peer.send_start();
    rchk(ADDR_STATUS, 32'h08); // start after stop
    wreg(ADDR_CTRL, 32'h0);
    rchk(ADDR_STATUS, 32'h00); // disable clears flags
    // Divider period per reload value
    for (int i = 0; i < 4; i++) begin
      wreg(ADDR_RELOAD, {24'h0, rl[i]});
      wreg(ADDR_CTRL, 32'h3);
      wait_oe(1'b1, n_lo);
      wait_oe(1'b0, n_lo);
      wait_oe(1'b1, n_hi);
      `CHK("scl period", per[i], n_lo + n_hi) // rate
      wreg(ADDR_CTRL, 32'h1);
    end
    results();
  end
endmodule
`default_nettype wire
